// ---- src/interrupt_dispatch_unit.sv ----
// interrupt dispatch unit with axi4-lite register access
// Behaviour
// - fifteen sources merged onto twelve vectored lines
// - global enable gates all lines but flash/debug
// - flash/debug gated only by its own enable
// - flash/debug priority 0, vector 0x33, fixed high level
// - ext0, timer0, ext1, timer1 vectors and levels
// - timer2, timer3, rtc via extended priority bits
// - serial0 tx/rx share line 5, vector 0x23
// - serial1 tx/rx share line 6, vector 0x3b
// - radio line 7 vector 0x43, own enable
// - converter/cipher share line 9, local enables
// - ext and timer0/1 flags auto clear on service
// - taken request jumps to its fixed vector
// - software writing one raises the request
// - only higher level preempts running routine
// - return ends current service level
// - finish current instruction before vectoring
// - return or enable/priority write delays one more
// - trap opcode a5 sets flash/debug flag
// - return opcode 32 takes four cycles
// - global enable bit 7, reset zero
// - flash write completion sets flash/debug flag
`timescale 1ns/1ps
module interrupt_dispatch_unit (
   input wire logic clk,
   input wire logic nrst,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [31:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic ext_input0_evt,
   input wire logic ext_input1_evt,
   input wire logic timer0_evt,
   input wire logic timer1_evt,
   input wire logic timer2_evt,
   input wire logic timer3_evt,
   input wire logic serial0_tx_evt,
   input wire logic serial0_rx_evt,
   input wire logic serial1_tx_evt,
   input wire logic serial1_rx_evt,
   input wire logic radio_evt,
   input wire logic converter_evt,
   input wire logic cipher_evt,
   input wire logic rtc_evt,
   input wire logic flash_write_done,
   input wire logic instr_done,
   input wire logic [7:0] instr_opcode,
   output logic irq_take,
   output logic [7:0] irq_vector,
   output logic [3:0] irq_active_level
);
   // line enables and levels, index = natural priority
   logic [7:0] primary_enable_reg;
   logic [7:0] extended_enable_reg;
   logic [7:0] primary_priority_reg;
   logic [7:0] extended_priority_reg;
   logic [7:0] ext_irq_control_reg;
   logic [11:0] line_flag;
   logic converter_local_flag;
   logic cipher_local_flag;
   logic converter_local_enable;
   logic cipher_local_enable;
   logic serial0_tx_flag, serial0_rx_flag;
   logic serial1_tx_flag, serial1_rx_flag;
   logic [1:0] in_service;
   logic [3:0] svc_line_hi, svc_line_lo;
   idu_pkg::idu_state_t state;
   logic prot_pend;
   // axi write staging
   logic aw_held, w_held;
   logic [5:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   wire global_irq_enable = primary_enable_reg[idu_pkg::global_en_bit];
   wire flashdbg_irq_enable =
      ext_irq_control_reg[idu_pkg::flashdbg_en_bit];
   wire flashdbg_irq_flag = line_flag[idu_pkg::flashdbg_line];
   wire [11:0] line_en = {extended_enable_reg[4:0],
      primary_enable_reg[6], primary_enable_reg[4:0], 1'b0};
   wire [11:0] line_level = {extended_priority_reg[4:0],
      primary_priority_reg[6], primary_priority_reg[4:0], 1'b1};
   wire conv_cipher_req =
      (converter_local_flag & converter_local_enable) |
      (cipher_local_flag & cipher_local_enable);
   wire [11:0] line_req_raw = {line_flag[11:10], line_flag[9] |
      conv_cipher_req, line_flag[8:7],
      line_flag[6] | serial1_tx_flag | serial1_rx_flag,
      line_flag[5] | serial0_tx_flag | serial0_rx_flag, line_flag[4:0]};
   wire [11:0] line_pending = {line_req_raw[11:1] & line_en[11:1] &
      {11{global_irq_enable}}, line_req_raw[0] & flashdbg_irq_enable};
   wire [11:0] pend_hi = line_pending & line_level;
   wire [11:0] pend_lo = line_pending & ~line_level;
   logic [3:0] pick_hi, pick_lo;
   logic any_hi, any_lo;
   always_comb begin
      pick_hi = 4'h0;
      pick_lo = 4'h0;
      any_hi = 1'b0;
      any_lo = 1'b0;
      for (int i = idu_pkg::num_lines - 1; i >= 0; i--) begin
         if (pend_hi[i]) begin
            pick_hi = 4'(i);
            any_hi = 1'b1;
         end
         if (pend_lo[i]) begin
            pick_lo = 4'(i);
            any_lo = 1'b1;
         end
      end
   end
   wire can_hi = any_hi & ~in_service[1];
   wire can_lo = any_lo & (in_service == 2'b00);
   wire take_ok = can_hi | can_lo;
   wire [3:0] take_line = can_hi ? pick_hi : pick_lo;
   wire take_level = can_hi;
   wire is_return_from_irq_opcode = instr_opcode == idu_pkg::return_from_irq_opcode_opcode;
   wire is_trap = instr_opcode == idu_pkg::trap_opcode;
   // bus handshake decode
   wire wr_fire = aw_held & w_held & ~s_axi_bvalid;
   wire wr_prot = wr_fire & (aw_addr == idu_pkg::primary_enable_off ||
      aw_addr == idu_pkg::extended_enable_off ||
      aw_addr == idu_pkg::primary_priority_off ||
      aw_addr == idu_pkg::extended_priority_off);
   wire wr_ok = wr_fire & (aw_addr <= idu_pkg::core_cmd_off) &
      (aw_addr[1:0] == 2'b00);
   wire [7:0] wb = w_strb[0] ? w_data[7:0] : 8'h00;
   wire wr_en = wr_fire & w_strb[0];
   // hold back after return or protected write
   wire delay_now = instr_done & (is_return_from_irq_opcode | wr_prot | prot_pend);
   wire take_now = instr_done & take_ok & ~delay_now;
   idu_pkg::idu_state_t next_state;
   assign next_state = delay_now ? idu_pkg::idu_extra :
      (instr_done ? idu_pkg::idu_run : state);

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state <= idu_pkg::idu_run;
         prot_pend <= 1'b0;
      end else begin
         state <= next_state;
         prot_pend <= ~instr_done & (prot_pend | wr_prot);
      end
   end

   // service level tracking
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         in_service <= 2'b00;
         svc_line_hi <= 4'h0;
         svc_line_lo <= 4'h0;
      end else if (take_now) begin
         if (take_level) begin
            in_service[1] <= 1'b1;
            svc_line_hi <= take_line;
         end else begin
            in_service[0] <= 1'b1;
            svc_line_lo <= take_line;
         end
      end else if (instr_done && is_return_from_irq_opcode) begin
         if (in_service[1]) begin
            in_service[1] <= 1'b0;
         end else begin
            in_service[0] <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_take <= 1'b0;
         irq_vector <= 8'h00;
      end else begin
         irq_take <= take_now;
         if (take_now) begin
            irq_vector <= idu_pkg::vec_table[take_line];
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_active_level <= 4'h0;
      end else begin
         irq_active_level <= {in_service, 2'b00};
      end
   end

   // flags: set beats clear
   logic [11:0] hw_set, sw_set, clr;
   always_comb begin
      hw_set = 12'h000;
      hw_set[0] = flash_write_done | (instr_done & is_trap);
      hw_set[1] = ext_input0_evt;
      hw_set[2] = timer0_evt;
      hw_set[3] = ext_input1_evt;
      hw_set[4] = timer1_evt;
      hw_set[7] = radio_evt;
      hw_set[8] = timer2_evt;
      hw_set[10] = timer3_evt;
      hw_set[11] = rtc_evt;
      sw_set = 12'h000;
      clr = 12'h000;
      if (wr_en && aw_addr == idu_pkg::flag_off) begin
         sw_set = {1'b0, wb[7:4], 2'b00, wb[3:0], 1'b0} & 12'h79e;
         clr = ~{1'b0, wb[7:4], 2'b00, wb[3:0], 1'b0} & 12'h79e;
      end
      if (wr_en && aw_addr == idu_pkg::ext_irq_control_off) begin
         sw_set[0] = wb[idu_pkg::flashdbg_flag_bit];
         clr[0] = ~wb[idu_pkg::flashdbg_flag_bit];
         sw_set[11] = wb[idu_pkg::rtc_flag_bit];
         clr[11] = ~wb[idu_pkg::rtc_flag_bit];
      end
      if (take_now && (take_line >= 4'h1) && (take_line <= 4'h4)) begin
         clr[take_line] = 1'b1;
      end
   end

   genvar g;
   generate
      for (g = 0; g < idu_pkg::num_lines; g++) begin : g_flag
         always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
               line_flag[g] <= 1'b0;
            end else if (hw_set[g] || sw_set[g]) begin
               line_flag[g] <= 1'b1;
            end else if (clr[g]) begin
               line_flag[g] <= 1'b0;
            end
         end
      end
   endgenerate

   // local flags for shared lines
   wire lw = wr_en && aw_addr == idu_pkg::local_ctrl_off;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         serial0_tx_flag <= 1'b0;
         serial0_rx_flag <= 1'b0;
         serial1_tx_flag <= 1'b0;
         serial1_rx_flag <= 1'b0;
         converter_local_flag <= 1'b0;
         cipher_local_flag <= 1'b0;
         converter_local_enable <= 1'b0;
         cipher_local_enable <= 1'b0;
      end else begin
         serial0_tx_flag <= serial0_tx_evt | (lw ? wb[0] : serial0_tx_flag);
         serial0_rx_flag <= serial0_rx_evt | (lw ? wb[1] : serial0_rx_flag);
         serial1_tx_flag <= serial1_tx_evt | (lw ? wb[2] : serial1_tx_flag);
         serial1_rx_flag <= serial1_rx_evt | (lw ? wb[3] : serial1_rx_flag);
         converter_local_flag <= converter_evt |
            (lw ? wb[4] : converter_local_flag);
         cipher_local_flag <= cipher_evt | (lw ? wb[5] : cipher_local_flag);
         if (lw) begin
            converter_local_enable <= wb[6];
            cipher_local_enable <= wb[7];
         end
      end
   end

   // control registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         primary_enable_reg <= idu_pkg::primary_enable_rst;
         extended_enable_reg <= idu_pkg::extended_enable_rst;
         primary_priority_reg <= 8'h00;
         extended_priority_reg <= idu_pkg::extended_enable_rst;
         ext_irq_control_reg <= idu_pkg::ext_ctrl_rst;
      end else if (wr_en) begin
         if (aw_addr == idu_pkg::primary_enable_off) begin
            primary_enable_reg <= wb;
         end
         if (aw_addr == idu_pkg::extended_enable_off) begin
            extended_enable_reg <= {3'h7, wb[4:0]};
         end
         if (aw_addr == idu_pkg::primary_priority_off) begin
            primary_priority_reg <= wb;
         end
         if (aw_addr == idu_pkg::extended_priority_off) begin
            extended_priority_reg <= {3'h7, wb[4:0]};
         end
         if (aw_addr == idu_pkg::ext_irq_control_off) begin
            ext_irq_control_reg <= {wb[7], 1'b1, wb[5], 5'h00};
         end
      end
   end

   // axi write channel; address and data in any order
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 6'h00;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr[31:6] == 26'h0 ? s_axi_awaddr[5:0] :
               6'h3f;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready = ~w_held & ~s_axi_bvalid;

   // read mux
   wire [5:0] ra = s_axi_araddr[5:0];
   wire ra_ok = s_axi_araddr[31:6] == 26'h0 && ra[1:0] == 2'b00 &&
      ra <= idu_pkg::core_cmd_off;
   wire [7:0] flag_view = {line_flag[10], line_flag[9], line_flag[8],
      line_flag[7], 4'h0};
   wire [7:0] local_view = {cipher_local_enable, converter_local_enable,
      cipher_local_flag, converter_local_flag, serial1_rx_flag,
      serial1_tx_flag, serial0_rx_flag, serial0_tx_flag};
   wire [7:0] ctrl_view = ext_irq_control_reg | {3'h0,
      line_flag[0], line_flag[11], 3'h0};
   wire [7:0] status_view = {state == idu_pkg::idu_extra, in_service,
      1'b0, take_line};
   wire [7:0] rd_byte =
      ra == idu_pkg::primary_enable_off ? primary_enable_reg :
      ra == idu_pkg::extended_enable_off ? extended_enable_reg :
      ra == idu_pkg::primary_priority_off ? primary_priority_reg :
      ra == idu_pkg::extended_priority_off ? extended_priority_reg :
      ra == idu_pkg::flag_off ? flag_view :
      ra == idu_pkg::ext_irq_control_off ? ctrl_view :
      ra == idu_pkg::local_ctrl_off ? local_view :
      ra == idu_pkg::status_off ? status_view : 8'h00;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= ra_ok ? {24'h0, rd_byte} : 32'h0;
         s_axi_rresp <= ra_ok ? 2'b00 : 2'b10;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
   assign s_axi_arready = ~s_axi_rvalid;
endmodule

// ---- src/idu_pkg.sv ----
// shared constants for the interrupt dispatch unit
package idu_pkg;
   // register byte offsets on the bus
   localparam logic [5:0] primary_enable_off = 6'h00;
   localparam logic [5:0] extended_enable_off = 6'h04;
   localparam logic [5:0] primary_priority_off = 6'h08;
   localparam logic [5:0] extended_priority_off = 6'h0c;
   localparam logic [5:0] flag_off = 6'h10;
   localparam logic [5:0] ext_irq_control_off = 6'h14;
   localparam logic [5:0] local_ctrl_off = 6'h18;
   localparam logic [5:0] status_off = 6'h1c;
   localparam logic [5:0] core_cmd_off = 6'h20;
   // field positions
   localparam int global_en_bit = 7;
   localparam int flashdbg_en_bit = 5;
   localparam int flashdbg_flag_bit = 4;
   localparam int rtc_flag_bit = 3;
   // reset values
   localparam logic [7:0] primary_enable_rst = 8'h00;
   localparam logic [7:0] extended_enable_rst = 8'he0;
   localparam logic [7:0] ext_ctrl_rst = 8'h40;
   // line count and index of the flash/debug line
   localparam int num_lines = 12;
   localparam int num_sources = 15;
   localparam int flashdbg_line = 0;
   // opcodes
   localparam logic [7:0] return_from_irq_opcode_opcode = 8'h32;
   localparam logic [7:0] trap_opcode = 8'ha5;
   localparam logic [2:0] return_from_irq_opcode_cycles = 3'h4;
   localparam logic [2:0] trap_cycles = 3'h3;
   // vectors indexed by natural priority
   localparam logic [7:0] vec_table [0:11] = '{
      8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23,
      8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
   typedef enum logic [1:0] {
      idu_run = 2'b00,
      idu_extra = 2'b01
   } idu_state_t;
endpackage

// ---- verification/idu_asserts.sv ----
// concurrent checks on the dispatch unit ports
`timescale 1ns/1ps
module idu_asserts (
   input wire logic clk,
   input wire logic nrst,
   input wire logic instr_done,
   input wire logic [7:0] instr_opcode,
   input wire logic irq_take,
   input wire logic [7:0] irq_vector,
   input wire logic [3:0] irq_active_level,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic [1:0] s_axi_rresp,
   input wire logic [31:0] s_axi_rdata
);
   wire logic return_from_irq_opcode_done = instr_done && instr_opcode == idu_pkg::return_from_irq_opcode_opcode;
   wire logic lvl_up = irq_active_level[3] || irq_active_level[2];
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   take_after_instr_a: assert property (
      irq_take |-> $past(instr_done)) else $error("take without instruction");
   take_vector_a: assert property (
      irq_take |-> irq_vector inside {idu_pkg::vec_table})
      else $error("vector outside table");
   vector_hold_a: assert property (
      $changed(irq_vector) |-> irq_take) else $error("vector moved alone");
   return_from_irq_opcode_gap_a: assert property (
      return_from_irq_opcode_done |=> !irq_take [*2]) else $error("take right after return");
   level_rise_a: assert property (
      $rose(irq_active_level[3]) || $rose(irq_active_level[2]) |->
      $past(irq_take) || $past(irq_take, 2)) else $error("level without take");
   level_fall_a: assert property (
      $fell(lvl_up) |-> $past(return_from_irq_opcode_done) || $past(return_from_irq_opcode_done, 2))
      else $error("level dropped without return");
   level_bits_a: assert property (
      irq_active_level[1:0] == 2'b00) else $error("spare level bits set");
   flash_high_a: assert property (
      irq_take && irq_vector == 8'h33 |-> ##[1:2] irq_active_level[3])
      else $error("flash line not high level");
   resp_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   slverr_zero_a: assert property (
      s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
      else $error("error read with data");
   cover property (irq_take && irq_vector == 8'h33);
   cover property (irq_active_level == 4'hc);
   cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule

// ---- verification/idu_core_model.sv ----
// core sequencer model: retires one instruction per request
`timescale 1ns/1ps
module idu_core_model (
   input wire logic clk,
   input wire logic nrst,
   input wire logic go,
   input wire logic slow,
   input wire logic [7:0] op,
   output logic instr_done,
   output logic [7:0] instr_opcode,
   output logic busy
);
   logic [2:0] cnt;
   logic [7:0] cur;
   logic [7:0] noise;
   wire logic [2:0] len = op == idu_pkg::return_from_irq_opcode_opcode ? idu_pkg::return_from_irq_opcode_cycles :
      op == idu_pkg::trap_opcode ? idu_pkg::trap_cycles : 3'h1;
   // opcode only valid with done, so scramble it otherwise
   assign instr_opcode = instr_done ? cur : noise;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt <= 3'h0;
         busy <= 1'b0;
         instr_done <= 1'b0;
         cur <= 8'h00;
         noise <= 8'h5a;
      end else begin
         noise <= noise + 8'h3b;
         instr_done <= busy && cnt == 3'h1;
         if (go && !busy) begin
            busy <= 1'b1;
            cur <= op;
            cnt <= len + (slow ? 3'h2 : 3'h0);
         end else if (busy) begin
            cnt <= cnt - 3'h1;
            busy <= cnt != 3'h1;
         end
      end
   end
endmodule

// ---- verification/tb.sv ----
// self-checking bench for the interrupt dispatch unit
`timescale 1ns/1ps
module tb;
   logic clk = 0;
   logic nrst = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, go = 0, slow = 0;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, instr_done, irq_take, busy;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [31:0] s_axi_rdata, rd;
   logic [7:0] instr_opcode, irq_vector, op = 0;
   logic [3:0] irq_active_level;
   logic [14:0] ev = 0;
   int n_errors = 0, checked = 0, s;
   int src_line [15] = '{1, 3, 2, 4, 8, 10, 5, 5, 6, 6, 7, 9, 9, 11, 0};
   always #20 clk = ~clk;
   interrupt_dispatch_unit dut (.*,
      .ext_input0_evt(ev[0]), .ext_input1_evt(ev[1]),
      .timer0_evt(ev[2]), .timer1_evt(ev[3]), .timer2_evt(ev[4]),
      .timer3_evt(ev[5]), .serial0_tx_evt(ev[6]), .serial0_rx_evt(ev[7]),
      .serial1_tx_evt(ev[8]), .serial1_rx_evt(ev[9]), .radio_evt(ev[10]),
      .converter_evt(ev[11]), .cipher_evt(ev[12]), .rtc_evt(ev[13]),
      .flash_write_done(ev[14]));
   idu_core_model core (.clk, .nrst, .go, .slow, .op, .instr_done,
      .instr_opcode, .busy);
   task automatic stop_test;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic lim(input int i);
      if (i >= 50) begin
         n_errors++;
         $display("CHECK FAILED handshake expected done seen timeout");
         stop_test();
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      s_axi_awvalid <= 1;
      s_axi_awaddr <= {26'h0, a};
      s_axi_wvalid <= 1;
      s_axi_wdata <= d;
      s_axi_bready <= 1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid) break;
      end
      lim(i);
      rs = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic rchk(input logic [5:0] a, input logic [31:0] e,
         input logic [1:0] r);
      int i;
      @(posedge clk);
      s_axi_arvalid <= 1;
      s_axi_araddr <= {26'h0, a};
      s_axi_rready <= 1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid) break;
      end
      lim(i);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 0;
      chk($sformatf("rdata %h", a), e, rd);
      chk($sformatf("rresp %h", a), r, rs);
   endtask
   task automatic pulse(input int n);
      @(posedge clk);
      ev[n] <= 1;
      @(posedge clk);
      ev[n] <= 0;
   endtask
   // one instruction; take is seen just after its done edge
   task automatic run(input logic [7:0] o, input logic t, input logic [7:0] v);
      int i;
      @(posedge clk);
      go <= 1;
      op <= o;
      slow <= 1'($urandom);
      @(posedge clk);
      go <= 0;
      for (i = 0; i < 50 && !instr_done; i++) @(posedge clk);
      lim(i);
      #1 chk("irq_take", t, irq_take);
      if (t) chk("irq_vector", v, irq_vector);
   endtask
   task automatic lvl(input logic [3:0] e);
      repeat (2) @(posedge clk);
      chk("level", e, irq_active_level);
   endtask
   task automatic clr;
      wr(idu_pkg::flag_off, 0);
      wr(idu_pkg::ext_irq_control_off, 32'h20);
      wr(idu_pkg::local_ctrl_off, 32'hc0);
   endtask
   initial begin
      void'($urandom(32'h5703));
      repeat (10) @(posedge clk);
      nrst <= 1;
      rchk(idu_pkg::primary_enable_off, 0, 0);
      rchk(idu_pkg::extended_enable_off, 32'he0, 0);
      rchk(idu_pkg::ext_irq_control_off, 32'h40, 0);
      rchk(6'h24, 0, 2'b10);
      wr(6'h24, 32'h1);
      chk("bresp", 2'b10, rs);
      $display("test reset_values done");
      wr(idu_pkg::primary_enable_off, 32'h02);
      pulse(2);
      run(8'h00, 0, 0);
      wr(idu_pkg::ext_irq_control_off, 32'h20);
      run(idu_pkg::trap_opcode, 0, 0);
      run(8'h00, 1, 8'h33);
      lvl(4'h8);
      rchk(idu_pkg::ext_irq_control_off, 32'h70, 0);
      wr(idu_pkg::ext_irq_control_off, 32'h20);
      run(idu_pkg::return_from_irq_opcode_opcode, 0, 0);
      pulse(14);
      run(8'h00, 1, 8'h33);
      clr();
      run(idu_pkg::return_from_irq_opcode_opcode, 0, 0);
      $display("test flash_line done");
      wr(idu_pkg::primary_enable_off, 32'hdf);
      wr(idu_pkg::extended_enable_off, 32'h1f);
      wr(idu_pkg::primary_priority_off, $urandom);
      wr(idu_pkg::extended_priority_off, $urandom);
      pulse(0);
      run(8'h00, 0, 0);
      // sweep every source once, then random repeats
      for (int k = 0; k < 30; k++) begin
         s = k < 15 ? k : $urandom % 15;
         pulse(s);
         run(8'h00, 1, idu_pkg::vec_table[src_line[s]]);
         if (s > 3) clr();
         run(idu_pkg::return_from_irq_opcode_opcode, 0, 0);
         repeat (2) run(8'h00, 0, 0);
      end
      wr(idu_pkg::flag_off, 32'h80);
      run(8'h00, 1, 8'h5b);
      clr();
      run(idu_pkg::return_from_irq_opcode_opcode, 0, 0);
      $display("test vectors done");
      wr(idu_pkg::primary_priority_off, 32'h02);
      wr(idu_pkg::extended_priority_off, 0);
      pulse(3);
      pulse(0);
      run(8'h00, 0, 0);
      run(8'h00, 1, 8'h03);
      run(8'h00, 0, 0);
      pulse(2);
      run(8'h00, 1, 8'h0b);
      lvl(4'hc);
      run(idu_pkg::return_from_irq_opcode_opcode, 0, 0);
      lvl(4'h4);
      run(idu_pkg::return_from_irq_opcode_opcode, 0, 0);
      run(8'h00, 1, 8'h1b);
      run(8'h00, 0, 0);
      run(idu_pkg::return_from_irq_opcode_opcode, 0, 0);
      $display("test preemption done");
      @(posedge clk);
      nrst <= 0;
      repeat (10) @(posedge clk);
      nrst <= 1;
      rchk(idu_pkg::primary_enable_off, 0, 0);
      $display("test second_reset done");
      stop_test();
   end
endmodule
bind interrupt_dispatch_unit idu_asserts u_chk (.clk(clk), .nrst(nrst),
   .instr_done(instr_done), .instr_opcode(instr_opcode),
   .irq_take(irq_take), .irq_vector(irq_vector),
   .irq_active_level(irq_active_level), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata));
